// file: logic/lmc_mission_regs.sv
// Mission control and status register bank of a data logger, APB slave.
// Assumes a real-time clock supplying second and minute ticks with
// the current time bytes, and a measurement engine answering each
// conversion request with a done pulse and a temperature value.
//
// Summary of operation
// (R1) Alarm bytes' bit 7 masks each field.
// (R2) Oscillator halts only on backup, idle, halt set.
// (R3) Armed clear command wipes logs, counters, rate.
// (R4) Armed then other command disarms, keeps data.
// (R5) Gated start needs rate nonzero, trigger low 0.5s.
// (R6) Ungated nonzero rate write starts mission.
// (R7) First sample only after start delay elapses.
// (R8) Wrap enabled: log pointer returns to zero.
// (R9) Full without wrap: stop logging, keep sampling.
// (R10) Interrupt low from flags with enable only.
// (R11) Result valid clears on read, sets on done.
// (R12) Wipe done sets on clear, clears on start.
// (R13) Logging active set on qualifying start.
// (R14) Clear or control write stops mission.
// (R15) Writing zero stops logging, one ignored.
// (R16) Conversion lasts at most 750ms, 250ms gap.
// (R17) Host avoids access while conversion active.
// (R18) Battery low reflects exhausted backup source.
// (R19) Temperature flags sticky, cleared by writing zero.
// (R20) Time match flag sticky until written zero.
// (R21) Sample interval is register value minutes.
// (R22) Rate writable only when wipe done; clear zeroes.
// (R23) Alarm compares seconds, minutes, hours, day.
// (R24) Interrupt returns high when no enabled flag.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module lmc_mission_regs
  import lmc_pkg::*;
#(
  parameter int CONV_MAX  = CONV_MAX_CYC,
  parameter int CONV_GAP  = CONV_GAP_CYC,
  parameter int TRIG_HOLD = TRIG_HOLD_CYC,
  parameter int LOG_AW    = $clog2(LOG_DEPTH)
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              secTick,
  input  wire logic              minTick,
  input  wire logic [7:0]        curSec,
  input  wire logic [7:0]        curMin,
  input  wire logic [7:0]        curHour,
  input  wire logic [7:0]        curDay,
  input  wire logic              vccPresent,
  input  wire logic              batteryExhausted,
  input  wire logic              triggerPin,
  input  wire logic              measDone,
  input  wire logic [7:0]        tempValue,
  input  wire logic [7:0]        tempHighLimit,
  input  wire logic [7:0]        tempLowLimit,
  output logic                   intN,
  output logic                   oscRun,
  output logic                   convStart,
  output logic                   logWrite,
  output logic      [LOG_AW-1:0] logAddr,
  output logic                   histStrobe,
  output logic                   wipeStrobe
);

  // ==========================================================================
  // State record
  typedef struct packed {
    logic              oscHalt;
    logic              wipeArm;
    logic              trigGate;
    logic              wrapEn;
    logic              belowEn;
    logic              aboveEn;
    logic              matchEn;
    logic              resultValid;
    logic              wipeDone;
    logic              convActive;
    logic              battLow;
    logic              belowFlag;
    logic              aboveFlag;
    logic              matchFlag;
    logic [7:0]        rate;
    logic [15:0]       startDelay;
    logic [3:0][7:0]   alm;
    lmc_mode_e         mode;
    logic [7:0]        minLeft;
    logic [23:0]       samples;
    logic [LOG_AW-1:0] logPtr;
    logic              logFull;
    logic              readPend;
    logic              missionPend;
    logic              convMission;
    logic [26:0]       convTimer;
    logic [26:0]       gapTimer;
    logic [26:0]       trigCnt;
    logic              intN;
    logic              oscRun;
    logic              convStart;
    logic              logWrite;
    logic [LOG_AW-1:0] logAddr;
    logic              histStrobe;
    logic              wipeStrobe;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } lmc_state_s;

  lmc_state_s s;
  lmc_state_s next_s;

  // An alarm field hits when masked or when its seven value bits agree.
  function automatic logic fieldHit(input logic [7:0] almByte,
                                    input logic [7:0] cur);
    fieldHit = almByte[AB_MASK] | (almByte[6:0] == cur[6:0]);
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic       wrDone;
    logic       stopReq;
    logic       startReq;
    logic       rdAcc;
    logic [7:0] wb;
    wrDone   = psel & penable & s.pready & pwrite;
    rdAcc    = psel & penable & ~s.pready;
    wb       = pwdata[7:0];
    stopReq  = 1'b0;
    startReq = 1'b0;
    next_s   = s;
    next_s.convStart  = 1'b0;
    next_s.logWrite   = 1'b0;
    next_s.histStrobe = 1'b0;
    next_s.wipeStrobe = 1'b0;
    next_s.pslverr    = 1'b0;
    next_s.battLow    = batteryExhausted;           // see (R18)

    // The answer comes one cycle into the access phase, so that read data
    // leaves a flip-flop rather than a decoder.
    next_s.pready = rdAcc;
    if (rdAcc) begin
      next_s.prdata = 32'h0;
      unique case (paddr)
        OFS_CTRL: begin
          next_s.prdata[CB_OSC_HALT]  = s.oscHalt;
          next_s.prdata[CB_WIPE_ARM]  = s.wipeArm;
          next_s.prdata[CB_TRIG_GATE] = s.trigGate;
          next_s.prdata[CB_WRAP]      = s.wrapEn;
          next_s.prdata[CB_BELOW_EN]  = s.belowEn;
          next_s.prdata[CB_ABOVE_EN]  = s.aboveEn;
          next_s.prdata[CB_MATCH_EN]  = s.matchEn;
        end
        OFS_STAT: begin
          next_s.prdata[SB_RESULT]  = s.resultValid;
          next_s.prdata[SB_WIPED]   = s.wipeDone;
          next_s.prdata[SB_LOGGING] = s.mode != LMC_IDLE;
          next_s.prdata[SB_CONV]    = s.convActive;
          next_s.prdata[SB_BATT]    = s.battLow;
          next_s.prdata[SB_BELOW]   = s.belowFlag;
          next_s.prdata[SB_ABOVE]   = s.aboveFlag;
          next_s.prdata[SB_MATCH]   = s.matchFlag;
        end
        OFS_RATE:    next_s.prdata[7:0]  = s.rate;
        OFS_ALM_SEC: next_s.prdata[7:0]  = s.alm[0];
        OFS_ALM_MIN: next_s.prdata[7:0]  = s.alm[1];
        OFS_ALM_HR:  next_s.prdata[7:0]  = s.alm[2];
        OFS_ALM_DAY: next_s.prdata[7:0]  = s.alm[3];
        OFS_DELAY:   next_s.prdata[15:0] = s.startDelay;
        OFS_CMD:     next_s.prdata       = 32'h0;
        OFS_SAMPLES: next_s.prdata[23:0] = s.samples;
        OFS_LOGPTR:  next_s.prdata[LOG_AW-1:0] = s.logPtr;
        default:     next_s.pslverr = 1'b1;
      endcase
    end

    // Write side effects take hold at the completing edge only.
    if (wrDone) begin
      unique case (paddr)
        OFS_CTRL: begin
          next_s.oscHalt  = wb[CB_OSC_HALT];
          next_s.wipeArm  = wb[CB_WIPE_ARM];
          next_s.trigGate = wb[CB_TRIG_GATE];
          next_s.wrapEn   = wb[CB_WRAP];
          next_s.belowEn  = wb[CB_BELOW_EN];
          next_s.aboveEn  = wb[CB_ABOVE_EN];
          next_s.matchEn  = wb[CB_MATCH_EN];
          stopReq = 1'b1;                           // see (R14)
        end
        OFS_STAT: begin
          if (!wb[SB_LOGGING]) begin
            stopReq = 1'b1;                         // see (R15)
          end
          if (!wb[SB_BELOW]) begin
            next_s.belowFlag = 1'b0;                // see (R19)
          end
          if (!wb[SB_ABOVE]) begin
            next_s.aboveFlag = 1'b0;                // see (R19)
          end
          if (!wb[SB_MATCH]) begin
            next_s.matchFlag = 1'b0;                // see (R20)
          end
        end
        OFS_RATE: begin
          if (s.wipeDone) begin
            next_s.rate = wb;                       // see (R22)
            if (!s.trigGate && wb != 8'h00) begin
              startReq = 1'b1;                      // see (R6)
            end
          end
        end
        OFS_ALM_SEC, OFS_ALM_MIN, OFS_ALM_HR, OFS_ALM_DAY: begin
          next_s.alm[paddr[3:2] - 2'h3] = wb;
          stopReq = 1'b1;                           // see (R14)
        end
        OFS_DELAY: begin
          next_s.startDelay = pwdata[15:0];
          stopReq = 1'b1;                           // see (R14)
        end
        OFS_CMD: begin
          // Any command disarms the wipe; only the clear acts on it.
          next_s.wipeArm = 1'b0;                    // see (R4)
          if (s.wipeArm && wb == CMD_CLEAR_MEM) begin
            stopReq           = 1'b1;               // see (R14)
            next_s.rate       = 8'h00;              // see (R22)
            next_s.startDelay = 16'h0;              // see (R3)
            next_s.samples    = 24'h0;
            next_s.logPtr     = '0;
            next_s.logFull    = 1'b0;
            next_s.wipeDone   = 1'b1;               // see (R12)
            next_s.wipeStrobe = 1'b1;
          end else if (wb == CMD_READ_DATA) begin
            next_s.resultValid = 1'b0;              // see (R11)
            next_s.readPend    = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Trigger hold: count cycles low while gated; fire once on crossing.
    // A bare falling edge is not enough, so a glitch cannot start a mission.
    if (!triggerPin && s.trigGate) begin
      if (s.trigCnt != 27'(TRIG_HOLD)) begin
        next_s.trigCnt = s.trigCnt + 27'h1;
      end
      if (s.trigCnt == 27'(TRIG_HOLD - 1) && s.rate != 8'h00) begin
        startReq = 1'b1;                            // see (R5)
      end
    end else begin
      next_s.trigCnt = 27'h0;
    end

    // Mission start and stop; a stop in the same cycle wins.
    // A stop also cancels a sample request that is still waiting.
    if (stopReq) begin
      next_s.mode        = LMC_IDLE;                // see (R14)
      next_s.missionPend = 1'b0;
    end else if (startReq && s.mode == LMC_IDLE) begin
      next_s.mode     = LMC_DELAY;                  // see (R13)
      next_s.wipeDone = 1'b0;                       // see (R12)
    end else if (minTick) begin
      // Minute sequencer: delay first, then one sample per interval.
      unique case (s.mode)
        LMC_DELAY: begin
          if (s.startDelay == 16'h0) begin
            next_s.mode        = LMC_RUN;           // see (R7)
            next_s.missionPend = 1'b1;
            next_s.minLeft     = s.rate;            // see (R21)
          end else begin
            next_s.startDelay = s.startDelay - 16'h1;
          end
        end
        LMC_RUN: begin
          if (s.minLeft <= 8'h01) begin
            next_s.missionPend = 1'b1;              // see (R21)
            next_s.minLeft     = s.rate;
          end else begin
            next_s.minLeft = s.minLeft - 8'h01;
          end
        end
        LMC_IDLE: ;
        default: next_s.mode = LMC_IDLE;
      endcase
    end

    // Conversion engine: bounded length, enforced quiet gap afterwards.
    if (s.gapTimer != 27'h0) begin
      next_s.gapTimer = s.gapTimer - 27'h1;
    end
    if (s.convActive) begin
      next_s.convTimer = s.convTimer + 27'h1;
      if (measDone || s.convTimer == 27'(CONV_MAX - 1)) begin
        next_s.convActive = 1'b0;                   // see (R16)
        next_s.gapTimer   = 27'(CONV_GAP);          // see (R16)
      end
      if (measDone) begin
        next_s.resultValid = 1'b1;                  // see (R11)
        if ($signed(tempValue) >= $signed(tempHighLimit)) begin
          next_s.aboveFlag = 1'b1;                  // see (R19)
        end
        if ($signed(tempValue) <= $signed(tempLowLimit)) begin
          next_s.belowFlag = 1'b1;                  // see (R19)
        end
        if (s.convMission && s.mode == LMC_RUN && !stopReq) begin
          next_s.histStrobe = 1'b1;                 // see (R9)
          next_s.samples    = s.samples + 24'h1;
          if (!s.logFull || s.wrapEn) begin
            next_s.logWrite = 1'b1;
            next_s.logAddr  = s.logPtr;
            next_s.logPtr   = s.logPtr + 1'b1;      // see (R8)
            next_s.logFull  = (&s.logPtr) & ~s.wrapEn; // see (R9)
          end
        end
      end
    end else if ((s.readPend || next_s.missionPend) && s.gapTimer == 27'h0) begin
      next_s.convActive  = 1'b1;
      next_s.convStart   = 1'b1;
      next_s.convTimer   = 27'h0;
      next_s.convMission = next_s.missionPend;
      next_s.readPend    = 1'b0;
      next_s.missionPend = 1'b0;
    end

    // Time-of-day alarm, checked once per second; a set beats a clear.
    if (secTick && fieldHit(s.alm[0], curSec) && fieldHit(s.alm[1], curMin)
        && fieldHit(s.alm[2], curHour) && fieldHit(s.alm[3], curDay)) begin
      next_s.matchFlag = 1'b1;                      // see (R1) (R20) (R23)
    end

    // Interrupt and oscillator follow the settled next values.
    next_s.intN = ~((next_s.belowFlag & next_s.belowEn)
                  | (next_s.aboveFlag & next_s.aboveEn)
                  | (next_s.matchFlag & next_s.matchEn)); // see (R10) (R24)
    next_s.oscRun = ~(next_s.oscHalt & ~vccPresent
                    & (next_s.mode == LMC_IDLE));   // see (R2)
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.wipeDone <= RST_WIPE_DONE;
      s.alm      <= {4{RST_ALARM}};
      s.mode     <= LMC_IDLE;
      s.intN     <= 1'b1;
      s.oscRun   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state record.
  assign prdata     = s.prdata;
  assign pready     = s.pready;
  assign pslverr    = s.pslverr;
  assign intN       = s.intN;
  assign oscRun     = s.oscRun;
  assign convStart  = s.convStart;
  assign logWrite   = s.logWrite;
  assign logAddr    = s.logAddr;
  assign histStrobe = s.histStrobe;
  assign wipeStrobe = s.wipeStrobe;

endmodule // lmc_mission_regs

// file: logic/lmc_pkg.sv
// Constants shared by the logger mission-control and status register bank.
// Assumes a 125 MHz clock; all times are turned into cycle counts here.
package lmc_pkg;

  // ==========================================================================
  // Clock and times
  localparam int TCK_NS          = 8;
  localparam int CONV_MAX_MS     = 750;
  localparam int CONV_GAP_MS     = 250;
  localparam int TRIG_HOLD_MS    = 500;
  // Longest time rounds down, least times round up.
  localparam int CONV_MAX_CYC    = (CONV_MAX_MS * 1000000) / TCK_NS;
  localparam int CONV_GAP_CYC    = (CONV_GAP_MS * 1000000 + TCK_NS - 1) / TCK_NS;
  localparam int TRIG_HOLD_CYC   = (TRIG_HOLD_MS * 1000000 + TCK_NS - 1) / TCK_NS;
  localparam int LOG_DEPTH       = 2048;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STAT    = 8'h04;
  localparam logic [7:0] OFS_RATE    = 8'h08;
  localparam logic [7:0] OFS_ALM_SEC = 8'h0c;
  localparam logic [7:0] OFS_ALM_MIN = 8'h10;
  localparam logic [7:0] OFS_ALM_HR  = 8'h14;
  localparam logic [7:0] OFS_ALM_DAY = 8'h18;
  localparam logic [7:0] OFS_DELAY   = 8'h1c;
  localparam logic [7:0] OFS_CMD     = 8'h20;
  localparam logic [7:0] OFS_SAMPLES = 8'h24;
  localparam logic [7:0] OFS_LOGPTR  = 8'h28;

  // ==========================================================================
  // Control bit positions
  localparam int CB_OSC_HALT  = 7;
  localparam int CB_WIPE_ARM  = 6;
  localparam int CB_TRIG_GATE = 4;
  localparam int CB_WRAP      = 3;
  localparam int CB_BELOW_EN  = 2;
  localparam int CB_ABOVE_EN  = 1;
  localparam int CB_MATCH_EN  = 0;
  // Status bit positions
  localparam int SB_RESULT    = 7;
  localparam int SB_WIPED     = 6;
  localparam int SB_LOGGING   = 5;
  localparam int SB_CONV      = 4;
  localparam int SB_BATT      = 3;
  localparam int SB_BELOW     = 2;
  localparam int SB_ABOVE     = 1;
  localparam int SB_MATCH     = 0;
  // Alarm byte mask bit.
  localparam int AB_MASK      = 7;

  // ==========================================================================
  // Commands and reset values
  localparam logic [7:0] CMD_CLEAR_MEM = 8'h3c;
  localparam logic [7:0] CMD_READ_DATA = 8'h5a;
  localparam logic       RST_WIPE_DONE = 1'b1;
  localparam logic [7:0] RST_ALARM     = 8'h80;

  typedef enum logic [1:0] {
    LMC_IDLE  = 2'b00,
    LMC_DELAY = 2'b01,
    LMC_RUN   = 2'b10
  } lmc_mode_e;

endpackage

// file: dv/lmc_meas_model.sv
// Measurement engine model on the far side of the register bank.
// Assumes one conversion request at a time, answered after LAT cycles.
`timescale 1ns/1ns
module lmc_meas_model #(
  parameter int LAT = 6
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic convStart,
  output logic      measDone
);
  int cnt;

  // ==========================================================================
  // Conversion timer
  // Each request ends well inside the longest conversion time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 0;
      measDone <= 1'b0;
    end else begin
      measDone <= (cnt == 1);
      if (convStart) cnt <= LAT;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule // lmc_meas_model

// file: dv/lmc_mission_sva.sv
// Port checker for the mission register bank, bound onto its top module.
// Assumes the bank's CONV_GAP and LOG_AW parameters are handed on.
`timescale 1ns/1ns
module lmc_mission_sva
  import lmc_pkg::*;
#(
  parameter int CONV_GAP = 20,
  parameter int LOG_AW   = 11
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [7:0]        paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              secTick,
  input wire logic              vccPresent,
  input wire logic              measDone,
  input wire logic              intN,
  input wire logic              oscRun,
  input wire logic              convStart,
  input wire logic              logWrite,
  input wire logic [LOG_AW-1:0] logAddr,
  input wire logic              histStrobe,
  input wire logic              wipeStrobe
);
  logic              hostWr;
  logic              clrCmd;
  int                gapCnt;
  logic              seenConv;
  logic [LOG_AW-1:0] nextPtr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Helper logic
  // A completed write and a clear command as seen on the bus.
  assign hostWr = psel && penable && pready && pwrite;
  assign clrCmd = hostWr && paddr == OFS_CMD && pwdata[7:0] == CMD_CLEAR_MEM;

  // Cycles since the last request, and the log address expected next.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt   <= 0;
      seenConv <= 1'b0;
      nextPtr  <= '0;
    end else begin
      gapCnt   <= convStart ? 0 : (gapCnt < 100000 ? gapCnt + 1 : gapCnt);
      seenConv <= seenConv | convStart;
      if (wipeStrobe) nextPtr <= '0;
      else if (logWrite) nextPtr <= logAddr + 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  a_intn_cause: assert property ($fell(intN) |-> $past(measDone) || $past(measDone, 2)
    || $past(secTick) || $past(secTick, 2) || $past(hostWr) || $past(hostWr, 2))
    else $error("interrupt fell without a flag or enable cause");
  a_intn_release: assert property ($rose(intN) |-> $past(hostWr) || $past(hostWr, 2))
    else $error("interrupt rose without a host write");
  a_osc_mains: assert property (vccPresent && $past(vccPresent) |-> oscRun)
    else $error("oscillator stopped on main power");
  a_conv_gap: assert property (convStart && seenConv |-> gapCnt >= CONV_GAP)
    else $error("conversion requests too close");
  a_conv_pulse: assert property (convStart |=> !convStart)
    else $error("conversion request longer than one cycle");
  a_log_hist: assert property (logWrite |-> histStrobe)
    else $error("log write without histogram update");
  a_ptr_step: assert property (logWrite |-> logAddr == nextPtr)
    else $error("log address out of sequence");
  a_wipe_cause: assert property (wipeStrobe |-> $past(clrCmd) || $past(clrCmd, 2))
    else $error("wipe without clear command");

  c_log_write: cover property (logWrite);
  c_irq_low: cover property ($fell(intN));
  c_wipe: cover property (wipeStrobe);
endmodule // lmc_mission_sva

bind lmc_mission_regs lmc_mission_sva #(.CONV_GAP(CONV_GAP), .LOG_AW(LOG_AW)) chk_u (
  .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pready(pready), .secTick(secTick), .vccPresent(vccPresent), .measDone(measDone),
  .intN(intN), .oscRun(oscRun), .convStart(convStart), .logWrite(logWrite), .logAddr(logAddr),
  .histStrobe(histStrobe), .wipeStrobe(wipeStrobe));

// file: dv/logger_mission_control_status_tb.sv
// Self-checking bench for the mission register bank over APB.
// Assumes the measurement model and the bound checker are compiled first.
`timescale 1ns/1ns
module logger_mission_control_status_tb;
  import lmc_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d;} lmc_row_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, secTick, minTick;
  logic vccPresent, batteryExhausted, triggerPin, measDone, intN, oscRun, convStart;
  logic logWrite, histStrobe, wipeStrobe;
  logic [10:0] logAddr;
  logic [7:0] paddr, curSec, tempValue;
  logic [31:0] pwdata, prdata, r;
  logic e;
  int n_errors = 0, compares = 0, cyc = 0;
  int nLog = 0, nHist = 0, nWipe = 0;
  lmc_row_s rows[10] = '{'{OFS_CTRL, 0, 0}, '{OFS_STAT, 0, 'h40}, '{OFS_RATE, 0, 0},
    '{OFS_ALM_SEC, 0, 'h80}, '{OFS_ALM_DAY, 0, 'h80}, '{OFS_CMD, 0, 0}, '{OFS_ALM_SEC, 1, 'h05},
    '{OFS_ALM_SEC, 0, 'h05}, '{OFS_CTRL, 1, 'h0b}, '{OFS_CTRL, 0, 'h0b}};

  lmc_mission_regs #(.CONV_MAX(50), .CONV_GAP(20), .TRIG_HOLD(10)) dut_u (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .secTick(secTick),
    .minTick(minTick), .curSec(curSec), .curMin(8'h00), .curHour(8'h00), .curDay(8'h01),
    .vccPresent(vccPresent), .batteryExhausted(batteryExhausted), .triggerPin(triggerPin),
    .measDone(measDone), .tempValue(tempValue), .tempHighLimit(8'h10), .tempLowLimit(8'hf0),
    .intN(intN), .oscRun(oscRun), .convStart(convStart), .logWrite(logWrite), .logAddr(logAddr),
    .histStrobe(histStrobe), .wipeStrobe(wipeStrobe));
  lmc_meas_model #(.LAT(6)) meas_u (.clk(clk), .rst_n(rst_n), .convStart(convStart), .measDone(measDone));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Log, histogram and wipe pulses are counted here so that the sequence can check them later.
  always @(posedge clk) begin
    cyc++;
    nLog += logWrite;
    nHist += histStrobe;
    nWipe += wipeStrobe;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Data is taken at the edge where pready is sampled high, and released there.
  // Only the watchdog ends a wait for an answer that never comes.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic tick(input logic m);
    @(posedge clk);
    secTick <= 1'b1; minTick <= m;
    @(posedge clk);
    secTick <= 1'b0; minTick <= 1'b0;
  endtask
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, secTick, minTick, batteryExhausted} = '0;
    {vccPresent, triggerPin} = 2'b11;
    paddr = '0; pwdata = '0; curSec = '0; tempValue = 8'h20;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("row", r, rows[i].d);
    end
    // Seconds alarm fires only on its own value.
    curSec <= 8'h05; tick(0);
    apb(OFS_STAT, 0, 0); chk("match", r & 1, 1);
    chk("irq", intN, 0);
    apb(OFS_STAT, 1, 0); @(negedge clk); chk("irq off", intN, 1);
    curSec <= 8'h06; tick(0);
    apb(OFS_STAT, 0, 0); chk("no match", r & 1, 0);
    // Ungated start, one sample, sticky high flag.
    apb(OFS_RATE, 1, 1); apb(OFS_STAT, 0, 0); chk("start", r, 'h20);
    tick(1); repeat (30) @(posedge clk);
    apb(OFS_STAT, 0, 0); chk("sample", r, 'ha2);
    chk("irq above", intN, 0);
    chk("log writes", nLog, 1);
    chk("hist", nHist, 1);
    chk("log addr", logAddr, 0);
    apb(OFS_RATE, 1, 5); apb(OFS_RATE, 0, 0); chk("rate lock", r, 1);
    apb(OFS_STAT, 1, 'h02); apb(OFS_STAT, 0, 0); chk("stop", r & 'h26, 'h02);
    // Armed then other command: read data measures, nothing is wiped.
    apb(OFS_CTRL, 1, 'h4b); apb(OFS_CMD, 1, CMD_READ_DATA);
    repeat (30) @(posedge clk);
    apb(OFS_CTRL, 0, 0); chk("disarm", r, 'h0b);
    apb(OFS_RATE, 0, 0); chk("kept rate", r, 1);
    apb(OFS_STAT, 0, 0); chk("result", r & 'h82, 'h82);
    chk("no mission log", nLog + nHist, 2);
    apb(OFS_CTRL, 1, 'h09); @(negedge clk); chk("masked", intN, 1);
    // Armed clear wipes rate and arm, keeps flags.
    apb(OFS_CTRL, 1, 'h49); apb(OFS_CMD, 1, CMD_CLEAR_MEM);
    apb(OFS_RATE, 0, 0); chk("wiped rate", r, 0);
    chk("wipe pulse", nWipe, 1);
    apb(OFS_CTRL, 0, 0); chk("arm clear", r, 'h09);
    apb(OFS_STAT, 0, 0); chk("wipe done", r & 'h42, 'h42);
    // Gated start waits for the trigger hold.
    apb(OFS_CTRL, 1, 'h10); apb(OFS_RATE, 1, 2);
    apb(OFS_STAT, 0, 0); chk("gate idle", r & 'h60, 'h40);
    triggerPin <= 1'b0; repeat (15) @(posedge clk); triggerPin <= 1'b1;
    apb(OFS_STAT, 0, 0); chk("gate start", r & 'h60, 'h20);
    apb(OFS_STAT, 1, 'h20); apb(OFS_STAT, 0, 0); chk("one ignored", r & 'h20, 'h20);
    apb(OFS_CTRL, 1, 'h10); apb(OFS_STAT, 0, 0); chk("ctrl stop", r & 'h20, 0);
    // Oscillator halt on backup only; battery status; unmapped access.
    vccPresent <= 1'b0; apb(OFS_CTRL, 1, 'h80); repeat (3) @(posedge clk);
    chk("osc halt", oscRun, 0);
    vccPresent <= 1'b1; repeat (3) @(posedge clk);
    chk("osc run", oscRun, 1);
    batteryExhausted <= 1'b1; repeat (2) @(posedge clk);
    apb(OFS_STAT, 0, 0); chk("battery", r & 8, 8);
    apb(8'h3c, 0, 0); chk("unmapped", e, 1);
    final_report();
  end
endmodule // logger_mission_control_status_tb
